//--- include/lars_pkg.sv
// Shared constants for the linear array readout sequencer.
// Assumes both ends and the link interface import this package.
`default_nettype none

package lars_pkg;

    // =========================================================
    // Array geometry
    localparam int NSEC = 2;
    localparam int SEC_PIX = 64;
    localparam int NPIX = NSEC * SEC_PIX;

    // =========================================================
    // Data widths
    localparam int LEVEL_W = 12;
    localparam int LIGHT_W = 8;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 12'hfff;
    localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 12'h000;

    // =========================================================
    // Sequence counts
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] END_COUNT = 8'h81;

    // =========================================================
    // Buffering between link and user
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W = NSEC * LEVEL_W;

endpackage : lars_pkg

`default_nettype wire

//--- include/lars_link_if.sv
// Link between the readout controller and the sensor array.
// Assumes one clock shared by both ends; pixel_clk is a one-cycle strobe.
`timescale 1ns/1ns
`default_nettype none

interface lars_link_if;
    import lars_pkg::*;

    logic pixel_clk;
    logic section_one_start_in;
    logic section_two_start_in;
    logic section_one_chain_out;
    logic section_two_chain_out;
    logic [LEVEL_W-1:0] section_one_pixel_out;
    logic section_one_pixel_oe;
    logic [LEVEL_W-1:0] section_two_pixel_out;
    logic section_two_pixel_oe;

    modport sensor (
        input pixel_clk,
        input section_one_start_in,
        input section_two_start_in,
        output section_one_chain_out,
        output section_two_chain_out,
        output section_one_pixel_out,
        output section_one_pixel_oe,
        output section_two_pixel_out,
        output section_two_pixel_oe
    );

    modport ctrl (
        output pixel_clk,
        output section_one_start_in,
        output section_two_start_in,
        input section_one_chain_out,
        input section_two_chain_out,
        input section_one_pixel_out,
        input section_one_pixel_oe,
        input section_two_pixel_out,
        input section_two_pixel_oe
    );

endinterface : lars_link_if

`default_nettype wire

//--- logic/lars_sensor.sv
// Sensor array end: two 64-pixel sections with integrators and readout.
// Also holds the small pixel FIFO that the controller end buffers into.
// Assumes the controller strobes pixel_clk and pulses the start inputs.
// Summary of operation
// - Two 64-pixel sections form one 128 line
// - Shift register sequences readout and integrator reset
// - Start high on one strobe begins readout
// - Controller drops start before the next strobe
// - Each stage gates one pixel onto output
// - Stage falling low resets that pixel integrator
// - Strobe 129 empties register, output goes undriven
// - Controller always supplies the 129th strobe
// - Next start no earlier than strobe 130
// - Integration time is the start pulse spacing
// - Output undriven whenever no readout is active
// - Each section start input begins its sequence
// - Section one chain out feeds section two
// - Section two chain out marks end of data
`timescale 1ns/1ns
`default_nettype none

module lars_sensor
    import lars_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    lars_link_if.sensor link,
    input wire logic [NPIX-1:0][LIGHT_W-1:0] light_level,
    output logic readout_active
);

    // =========================================================
    // State
    typedef struct packed {
        logic [NSEC-1:0][SEC_PIX-1:0] stage;
        logic [NPIX-1:0][LEVEL_W-1:0] charge;
        logic [NSEC-1:0][LEVEL_W-1:0] pix;
        logic [NSEC-1:0] oe;
        logic [NSEC-1:0] chain;
        logic active;
    } lars_sensor_st_t;

    lars_sensor_st_t st_q;
    lars_sensor_st_t st_d;

    // =========================================================
    // Helpers
    // Saturate instead of wrapping so a bright pixel never reads dark
    function automatic logic [LEVEL_W-1:0] lars_sat_add(
        input logic [LEVEL_W-1:0] acc,
        input logic [LIGHT_W-1:0] inc
    );
        logic [LEVEL_W:0] sum;
        sum = {1'b0, acc} + {{(LEVEL_W+1-LIGHT_W){1'b0}}, inc};
        if (sum[LEVEL_W])
        begin
            lars_sat_add = LEVEL_MAX;
        end
        else
        begin
            lars_sat_add = sum[LEVEL_W-1:0];
        end
    endfunction : lars_sat_add

    // One-hot select of a section's charges; zero when no stage is set
    function automatic logic [LEVEL_W-1:0] lars_pick(
        input logic [SEC_PIX-1:0] sel,
        input logic [SEC_PIX-1:0][LEVEL_W-1:0] vals
    );
        logic [LEVEL_W-1:0] acc;
        acc = LEVEL_ZERO;
        for (int i = 0; i < SEC_PIX; i++)
        begin
            if (sel[i])
            begin
                acc = acc | vals[i];
            end
        end
        lars_pick = acc;
    endfunction : lars_pick

    // =========================================================
    // Next state
    logic [NSEC-1:0] start_in;
    logic [NSEC-1:0][SEC_PIX-1:0][LEVEL_W-1:0] sec_charge;

    assign start_in[0] = link.section_one_start_in;
    assign start_in[1] = link.section_two_start_in;

    // Pixel numbering is contiguous: section two follows section one
    genvar gs;
    generate
        for (gs = 0; gs < NSEC; gs++)
        begin : g_sec
            assign sec_charge[gs] =
                st_q.charge[gs*SEC_PIX +: SEC_PIX];
        end
    endgenerate

    always_comb
    begin
        st_d = st_q;
        // Integrators run every cycle; only a readout pass or reset clears them,
        // so exposure equals the spacing of start pulses
        for (int p = 0; p < NPIX; p++)
        begin
            st_d.charge[p] = lars_sat_add(st_q.charge[p],
                light_level[p]);
        end
        if (link.pixel_clk)
        begin
            for (int s = 0; s < NSEC; s++)
            begin
                // Start bit enters stage 0 and walks one per strobe
                st_d.stage[s] = {st_q.stage[s][SEC_PIX-2:0],
                    start_in[s]};
                // Stage just set puts its pixel on the output
                st_d.pix[s] = lars_pick(st_d.stage[s],
                    sec_charge[s]);
                // Bit leaving the last stage leaves oe low
                st_d.oe[s] = |st_d.stage[s];
                // Chain out tracks the final stage for one strobe period
                st_d.chain[s] = st_d.stage[s][SEC_PIX-1];
                for (int i = 0; i < SEC_PIX; i++)
                begin
                    if (st_q.stage[s][i] && !st_d.stage[s][i])
                    begin
                        st_d.charge[s*SEC_PIX+i] = LEVEL_ZERO;
                    end
                end
            end
            st_d.active = |st_d.oe;
        end
        if (!rst_n)
        begin
            st_d = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_q <= st_d;
    end

    // =========================================================
    // Outputs
    // Undriven analog output is shown as oe low; the value reads zero
    assign link.section_one_pixel_out = st_q.pix[0];
    assign link.section_one_pixel_oe = st_q.oe[0];
    assign link.section_two_pixel_out = st_q.pix[1];
    assign link.section_two_pixel_oe = st_q.oe[1];
    assign link.section_one_chain_out = st_q.chain[0];
    assign link.section_two_chain_out = st_q.chain[1];
    assign readout_active = st_q.active;

endmodule : lars_sensor

module lars_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // =========================================================
    // State
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } lars_fifo_st_t;

    lars_fifo_st_t st_q;
    lars_fifo_st_t st_d;
    logic do_wr;
    logic do_rd;

    assign in_ready = (st_q.cnt != CW'(DEPTH));
    assign out_valid = (st_q.cnt != '0);
    assign out_data = st_q.mem[st_q.rd];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb
    begin
        st_d = st_q;
        if (do_wr)
        begin
            st_d.mem[st_q.wr] = in_data;
            st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
        end
        if (do_rd)
        begin
            st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
        end
        if (do_wr && !do_rd)
        begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
        else if (do_rd && !do_wr)
        begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        if (!rst_n)
        begin
            st_d = '0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_q <= st_d;
    end

endmodule : lars_fifo

`default_nettype wire

//--- logic/lars_ctrl.sv
// Controller end: strobes the array, collects pixels into a small FIFO.
// Assumes the sensor end shares sys_clk and updates on pixel_clk strobes.
`timescale 1ns/1ns
`default_nettype none

module lars_ctrl
    import lars_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    lars_link_if.ctrl link,
    input wire logic frame_req,
    input wire logic parallel_mode,
    output logic pix_valid,
    input wire logic pix_ready,
    output logic [FIFO_W-1:0] pix_data,
    output logic frame_done,
    output logic busy
);

    // =========================================================
    // State
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STROBE,
        ST_WAIT,
        ST_SAMPLE
    } lars_ctrl_state_t;

    typedef struct packed {
        lars_ctrl_state_t state;
        logic [CNT_W-1:0] count;
        logic par;
        logic pclk;
        logic sec_one_start;
        logic sec_two_start;
        logic push;
        logic [FIFO_W-1:0] data;
        logic done;
        logic busy;
    } lars_ctrl_st_t;

    lars_ctrl_st_t st_q;
    lars_ctrl_st_t st_d;
    logic fifo_ready;

    lars_fifo #(
        .W(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(st_q.push),
        .in_ready(fifo_ready),
        .in_data(st_q.data),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data(pix_data)
    );

    // =========================================================
    // Sequencer
    always_comb
    begin
        st_d = st_q;
        st_d.pclk = 1'b0;
        st_d.sec_one_start = 1'b0;
        st_d.sec_two_start = 1'b0;
        st_d.push = 1'b0;
        st_d.done = 1'b0;
        case (st_q.state)
            ST_IDLE:
            begin
                st_d.busy = 1'b0;
                if (frame_req)
                begin
                    st_d.count = CNT_ZERO;
                    st_d.par = parallel_mode;
                    st_d.busy = 1'b1;
                    st_d.state = ST_STROBE;
                end
            end
            ST_STROBE:
            begin
                // Strobe only with FIFO room, so a slow user stalls the scan
                if (fifo_ready && !st_q.push)
                begin
                    st_d.pclk = 1'b1;
                    st_d.count = st_q.count + CNT_ONE;
                    st_d.sec_one_start =
                        (st_q.count == CNT_ZERO);
                    st_d.sec_two_start = st_q.par
                        ? (st_q.count == CNT_ZERO)
                        : link.section_one_chain_out;
                    st_d.state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                st_d.state = ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
                st_d.push = link.section_one_pixel_oe
                    || link.section_two_pixel_oe;
                st_d.data = {link.section_two_pixel_out,
                    link.section_one_pixel_out};
                if (st_q.count == END_COUNT)
                begin
                    // Next frame's first strobe is at least the 130th
                    st_d.done = 1'b1;
                    st_d.state = ST_IDLE;
                end
                else
                begin
                    st_d.state = ST_STROBE;
                end
            end
            default:
            begin
                st_d.state = ST_IDLE;
            end
        endcase
        if (!rst_n)
        begin
            st_d = '0;
            st_d.state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_q <= st_d;
    end

    // =========================================================
    // Outputs
    assign link.pixel_clk = st_q.pclk;
    assign link.section_one_start_in = st_q.sec_one_start;
    assign link.section_two_start_in = st_q.sec_two_start;
    assign frame_done = st_q.done;
    assign busy = st_q.busy;

endmodule : lars_ctrl

`default_nettype wire

//--- tb/lars_link_sva.sv
// Assertions on the link between controller and sensor ends.
// Assumes one clock; instantiated beside the link interface.
`timescale 1ns/1ns
`default_nettype none

module lars_link_sva
    import lars_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pixel_clk,
    input wire logic section_one_start_in,
    input wire logic section_two_start_in,
    input wire logic section_one_chain_out,
    input wire logic section_two_chain_out,
    input wire logic [LEVEL_W-1:0] section_one_pixel_out,
    input wire logic section_one_pixel_oe,
    input wire logic [LEVEL_W-1:0] section_two_pixel_out,
    input wire logic section_two_pixel_oe
);
    // ==========================================================
    // Strobes seen while section one drives its output
    logic [CNT_W-1:0] pix_cnt_q;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !section_one_pixel_oe)
            pix_cnt_q <= CNT_ZERO;
        else if (pixel_clk)
            pix_cnt_q <= pix_cnt_q + CNT_ONE;
    end

    // ==========================================================
    // Link properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    start_in_strobe_a: assert property (
        section_one_start_in |-> pixel_clk) else $error("start off strobe");
    start_two_strobe_a: assert property (
        section_two_start_in |-> pixel_clk)
        else $error("start two off strobe");
    start_once_a: assert property (
        section_one_start_in |=> !section_one_start_in [*2])
        else $error("start held");
    first_pixel_a: assert property (
        pixel_clk && section_one_start_in |=> section_one_pixel_oe)
        else $error("no first pixel");
    out_stands_a: assert property (
        !pixel_clk |=> $stable(section_one_pixel_oe)
            && $stable(section_two_pixel_oe)) else $error("oe moved");
    idle_zero_a: assert property (
        !section_one_pixel_oe && !section_two_pixel_oe |->
            section_one_pixel_out == LEVEL_ZERO
            && section_two_pixel_out == LEVEL_ZERO)
        else $error("idle output");
    chain_one_a: assert property (
        section_one_chain_out && pixel_clk |=> !section_one_chain_out)
        else $error("chain one long");
    chain_two_a: assert property (
        section_two_chain_out && pixel_clk |=> !section_two_chain_out)
        else $error("chain two long");
    sec_one_end_a: assert property (
        $fell(section_one_chain_out) |-> !section_one_pixel_oe)
        else $error("sec one still on");
    last_pixel_a: assert property (
        $fell(section_two_chain_out) |->
            !section_two_pixel_oe && !section_one_pixel_oe)
        else $error("output after end");
    pixel_count_a: assert property (
        $fell(section_one_pixel_oe) |-> pix_cnt_q == 8'h40)
        else $error("pixel count");
endmodule : lars_link_sva

`default_nettype wire

//--- tb/testbench.sv
// Top bench: both ends joined by the link, checker beside it.
// Assumes lars_pkg, lars_link_if and both ends are compiled first.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import lars_pkg::*;
    logic sys_clk;
    logic rst_n;
    logic frame_req;
    logic parallel_mode;
    logic pix_ready;
    logic pix_valid;
    logic [FIFO_W-1:0] pix_data;
    logic frame_done;
    logic busy;
    logic readout_active;
    logic [NPIX-1:0][LIGHT_W-1:0] light_level;
    int n_fail;
    int cmp_count;
    int cyc;
    int strobes;
    int starts;
    int ends;
    int dones;

    lars_link_if lars_link_if_i ();
    lars_sensor lars_sensor_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(lars_link_if_i), .light_level(light_level),
        .readout_active(readout_active));
    lars_ctrl lars_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .link(lars_link_if_i), .frame_req(frame_req),
        .parallel_mode(parallel_mode), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_data(pix_data),
        .frame_done(frame_done), .busy(busy));
    lars_link_sva lars_link_sva_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .pixel_clk(lars_link_if_i.pixel_clk),
        .section_one_start_in(lars_link_if_i.section_one_start_in),
        .section_two_start_in(lars_link_if_i.section_two_start_in),
        .section_one_chain_out(lars_link_if_i.section_one_chain_out),
        .section_two_chain_out(lars_link_if_i.section_two_chain_out),
        .section_one_pixel_out(lars_link_if_i.section_one_pixel_out),
        .section_one_pixel_oe(lars_link_if_i.section_one_pixel_oe),
        .section_two_pixel_out(lars_link_if_i.section_two_pixel_out),
        .section_two_pixel_oe(lars_link_if_i.section_two_pixel_oe));

    // ==========================================================
    // Clock, wire monitor and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cyc++;
        if (lars_link_if_i.pixel_clk === 1'b1)
            strobes++;
        if (lars_link_if_i.pixel_clk && lars_link_if_i.section_one_start_in)
            starts++;
        if (lars_link_if_i.pixel_clk && lars_link_if_i.section_two_chain_out)
            ends++;
        if (frame_done === 1'b1)
            dones++;
        if (cyc == 20000)
        begin
            n_fail++;
            test_done();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic test_done();
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Light 0 stays dark, light ff saturates well inside a frame
    function automatic logic [LEVEL_W-1:0] lvl(input int p);
        return (p % 3 == 0) ? LEVEL_ZERO : LEVEL_MAX;
    endfunction : lvl

    task automatic pop(input logic [FIFO_W-1:0] exp, input int stall);
        int n;
        n = 0;
        // Ready stays up across back-to-back pops so it moves once a step
        if (stall > 0)
            pix_ready = 1'b0;
        repeat (stall) @(negedge sys_clk);
        while (pix_valid !== 1'b1 && n < 2000)
        begin
            pix_ready = 1'b0;
            @(negedge sys_clk);
            n++;
        end
        if (n >= 2000)
            n_fail++;
        check({8'h00, pix_data}, {8'h00, exp});
        pix_ready = 1'b1;
        @(negedge sys_clk);
    endtask : pop

    task automatic start_frame(input logic par);
        int n;
        n = 0;
        strobes = 0;
        starts = 0;
        ends = 0;
        dones = 0;
        parallel_mode = par;
        frame_req = 1'b1;
        while (busy !== 1'b1 && n < 100)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 100)
            n_fail++;
        frame_req = 1'b0;
    endtask : start_frame

    task automatic finish_frame();
        int n;
        n = 0;
        pix_ready = 1'b0;
        while (busy !== 1'b0 && n < 1000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 1000)
            n_fail++;
        repeat (2) @(negedge sys_clk);
        check(strobes, 32'h81);
        check(starts, 32'h1);
        check(ends, 32'h1);
        check(dones, 32'h1);
        check({31'h0, readout_active}, 32'h0);
    endtask : finish_frame

    // ==========================================================
    // Scenarios; a long first stall fills the FIFO and halts strobes
    // A dark frame reads zero only if read-out cleared each integrator
    task automatic frame_serial(input logic dark);
        start_frame(1'b0);
        for (int i = 0; i < NPIX; i++)
            pop(dark ? {LEVEL_ZERO, LEVEL_ZERO}
                : i < SEC_PIX ? {LEVEL_ZERO, lvl(i)} : {lvl(i), LEVEL_ZERO},
                i == 0 ? 40 : i % 2);
        finish_frame();
    endtask : frame_serial

    task automatic frame_parallel();
        start_frame(1'b1);
        for (int i = 0; i < SEC_PIX; i++)
            pop({lvl(i + SEC_PIX), lvl(i)}, i == 0 ? 40 : 0);
        finish_frame();
    endtask : frame_parallel

    task automatic frame_abort();
        start_frame(1'b0);
        for (int i = 0; i < 3; i++)
            pop({LEVEL_ZERO, lvl(i)}, 0);
        rst_n = 1'b0;
        pix_ready = 1'b0;
        repeat (3) @(negedge sys_clk);
        check({31'h0, busy}, 32'h0);
        check({31'h0, lars_link_if_i.section_one_pixel_oe}, 32'h0);
        rst_n = 1'b1;
        repeat (30) @(negedge sys_clk);
    endtask : frame_abort

    initial
    begin
        rst_n = 1'b0;
        frame_req = 1'b0;
        parallel_mode = 1'b0;
        pix_ready = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        for (int p = 0; p < NPIX; p++)
            light_level[p] = (p % 3 == 0) ? 8'h00 : 8'hff;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (30) @(negedge sys_clk);
        frame_serial(1'b0);
        frame_parallel();
        frame_serial(1'b0);
        frame_abort();
        // Go dark: this frame still shows held charge, the next only zeros
        for (int p = 0; p < NPIX; p++)
            light_level[p] = 8'h00;
        frame_serial(1'b0);
        frame_serial(1'b1);
        test_done();
    end
endmodule : testbench

`default_nettype wire
